// *** hw/qpc_pkg.sv ***
// qpc_pkg: register map, field layout and shared types of the quad frame phase block.
// assumes a 12-bit byte address on the register port and 32-bit data words.
package qpc_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  localparam int BUF_DEPTH = 2;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFS_QUAD_CTRL = 12'h0f4;
  localparam logic [ADDR_W-1:0] OFS_FRAME_CMD = 12'h0f8;
  localparam logic [ADDR_W-1:0] OFS_FRAME_STAT = 12'h0fc;
  localparam logic [ADDR_W-1:0] OFS_PIN_SWAP = 12'h200;

  // quad_phase_control fields
  localparam int IAT_LSB = 0;
  localparam int ALEN_LSB = 2;
  localparam int ILEN_LSB = 8;
  localparam int WAIT_LSB = 11;
  localparam int STRETCH_BIT = 30;
  localparam logic [DATA_W-1:0] QCTRL_MASK = 32'h4000_fb3f;
  localparam logic [DATA_W-1:0] QCTRL_RESET = 32'h0000_0000;

  // pin_route_swap
  localparam logic [DATA_W-1:0] SWAP_MASK = 32'h0000_0001;
  localparam logic SWAP_RESET = 1'h0;

  // frame command and status
  localparam int CMD_START_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int CMD_WORDS_LSB = 8;
  localparam logic [DATA_W-1:0] CMD_MASK = 32'h0000_ff02;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_UNDER_BIT = 1;
  localparam int STAT_OVER_BIT = 2;
  localparam int STAT_STALL_BIT = 3;

  // instr_addr_format codes
  localparam logic [1:0] IAT_BOTH_STD = 2'h0;
  localparam logic [1:0] IAT_ADDR_FRF = 2'h1;
  localparam logic [1:0] IAT_BOTH_FRF = 2'h2;

  // frame format codes
  localparam logic [1:0] FRF_STD = 2'h0;
  localparam logic [1:0] FRF_DUAL = 2'h1;
  localparam logic [1:0] FRF_QUAD = 2'h2;

  // instruction bits when not in quad mode, data word bits and the address length code limit
  localparam logic [6:0] STD_INSTR_BITS = 7'h08;
  localparam logic [6:0] WORD_BITS = 7'h20;
  localparam logic [3:0] ALEN_MAX = 4'h8;

  typedef enum logic [2:0] {ST_IDLE, ST_INSTR, ST_ADDR, ST_DUMMY, ST_DATA} qpc_state_t;

endpackage : qpc_pkg

// *** hw/qpc_sync3.sv ***
// qpc_sync3: three-stage input synchroniser for pin inputs.
// assumes the inputs are asynchronous to clk_sys; output moves once stages two and three agree.
`timescale 1ns/100ps
module qpc_sync3 #(
  parameter int W = 4
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;
  logic [W-1:0] next_dout;

  // stage1 feeds stage2 only, to keep metastability contained
  always_comb begin
    next_dout = dout;
    if (stage2 == stage3) begin
      next_dout = stage3;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      stage2 <= stage1;
      stage3 <= stage2;
      dout   <= next_dout;
    end
  end

endmodule : qpc_sync3

// *** hw/qpc_pair_buf.sv ***
// qpc_pair_buf: two-entry buffer with valid and ready on both sides.
// assumes a same-clock source and sink; inReady is registered.
`timescale 1ns/100ps
module qpc_pair_buf #(
  parameter int W = 32
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic         inValid,
  input  wire logic [W-1:0] inData,
  output logic              inReady,
  output logic              outValid,
  output logic      [W-1:0] outData,
  input  wire logic         outReady
);

  logic [W-1:0] mem [qpc_pkg::BUF_DEPTH];
  logic         wrPtr;
  logic         rdPtr;
  logic [1:0]   count;
  logic         next_wrPtr;
  logic         next_rdPtr;
  logic [1:0]   next_count;
  logic         push;
  logic         pop;

  assign outValid = (count != 2'h0);
  assign outData  = mem[rdPtr];

  always_comb begin
    push       = inValid && inReady;
    pop        = outValid && outReady;
    next_wrPtr = wrPtr ^ push;
    next_rdPtr = rdPtr ^ pop;
    next_count = count;
    if (push && !pop) begin
      next_count = count + 2'h1;
    end else if (pop && !push) begin
      next_count = count - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wrPtr   <= 1'b0;
      rdPtr   <= 1'b0;
      count   <= 2'h0;
      inReady <= 1'b0;
    end else begin
      wrPtr   <= next_wrPtr;
      rdPtr   <= next_rdPtr;
      count   <= next_count;
      inReady <= (next_count != 2'h2);
    end
  end

  // storage needs no reset; count guards it
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

endmodule : qpc_pair_buf

// *** hw/qpc_frame_ctrl.sv ***
// qpc_frame_ctrl: instruction, address, dummy and data phase sequencer with clock stretching.
// assumes a simple strobe register port and an external flash on four io lanes.
`timescale 1ns/100ps
module qpc_frame_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [11:0] regAddr,
  input  wire logic [31:0] regWrData,
  input  wire logic        regWrStb,
  input  wire logic        regRdStb,
  output logic      [31:0] regRdData,
  input  wire logic [1:0]  spiFrf,
  input  wire logic [15:0] instrCode,
  input  wire logic        txValid,
  input  wire logic [31:0] txData,
  output logic             txReady,
  output logic             rxValid,
  output logic      [31:0] rxData,
  input  wire logic        rxReady,
  output logic             sclk,
  output logic             csN,
  input  wire logic [3:0]  ioIn,
  output logic      [3:0]  ioOut,
  output logic      [3:0]  ioOeN,
  output logic             pinSwapSel,
  output logic             busy
);

  logic [31:0] qctrl;
  logic        cmdRead;
  logic [7:0]  cmdWords;
  logic        startReq;
  logic        clrUnder;
  logic        clrOver;
  logic [31:0] next_qctrl;
  logic        next_pinSwapSel;
  logic        next_cmdRead;
  logic [7:0]  next_cmdWords;
  logic        next_startReq;
  logic        next_clrUnder;
  logic        next_clrOver;
  logic [31:0] next_regRdData;

  qpc_pkg::qpc_state_t st;
  qpc_pkg::qpc_state_t next_st;
  qpc_pkg::qpc_state_t tgt;
  logic [6:0]  bitsLeft;
  logic [6:0]  next_bitsLeft;
  logic [31:0] shOut;
  logic [31:0] next_shOut;
  logic [31:0] shIn;
  logic [31:0] next_shIn;
  logic [2:0]  laneW;
  logic [2:0]  next_laneW;
  logic [7:0]  wordsLeft;
  logic [7:0]  next_wordsLeft;
  logic        startPend;
  logic        next_startPend;
  logic        rdDir;
  logic        next_rdDir;
  logic        rxPend;
  logic        next_rxPend;
  logic        under;
  logic        next_under;
  logic        over;
  logic        next_over;
  logic        stall;
  logic        next_stall;
  logic        next_sclk;
  logic        next_csN;
  logic        next_rxValid;
  logic [31:0] next_rxData;
  logic [3:0]  next_ioOut;
  logic [3:0]  next_ioOeN;
  logic        next_busy;

  logic        bufValid;
  logic [31:0] bufData;
  logic        bufPop;
  logic [3:0]  ioSync;

  logic [1:0]  instr_addr_format;
  logic [3:0]  alen;
  logic [1:0]  ilen;
  logic [4:0]  waitCnt;
  logic        stretch;
  logic        quad;
  logic [2:0]  frfLane;
  logic [6:0]  instrBits;
  logic [6:0]  addrBits;
  logic [6:0]  dummyBits;
  logic [2:0]  instrLane;
  logic [2:0]  addrLane;
  logic        doEnter;
  logic        endFrame;
  logic        hold;

  qpc_pair_buf #(.W(32)) u_txbuf (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .inValid  (txValid),
    .inData   (txData),
    .inReady  (txReady),
    .outValid (bufValid),
    .outData  (bufData),
    .outReady (bufPop)
  );

  qpc_sync3 #(.W(4)) u_iosync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (ioIn),
    .dout    (ioSync)
  );

  // register file
  always_comb begin
    next_qctrl      = qctrl;
    next_pinSwapSel = pinSwapSel;
    next_cmdRead    = cmdRead;
    next_cmdWords   = cmdWords;
    next_startReq   = 1'b0;
    next_clrUnder   = 1'b0;
    next_clrOver    = 1'b0;
    next_regRdData  = 32'h0;
    if (regWrStb) begin
      case (regAddr)
        qpc_pkg::OFS_QUAD_CTRL: next_qctrl = regWrData & qpc_pkg::QCTRL_MASK;
        qpc_pkg::OFS_PIN_SWAP: next_pinSwapSel = regWrData[0];
        qpc_pkg::OFS_FRAME_CMD: begin
          next_cmdRead  = regWrData[qpc_pkg::CMD_READ_BIT];
          next_cmdWords = regWrData[qpc_pkg::CMD_WORDS_LSB +: 8];
          next_startReq = regWrData[qpc_pkg::CMD_START_BIT];
        end
        qpc_pkg::OFS_FRAME_STAT: begin
          next_clrUnder = regWrData[qpc_pkg::STAT_UNDER_BIT];
          next_clrOver  = regWrData[qpc_pkg::STAT_OVER_BIT];
        end
        default: ;
      endcase
    end
    if (regRdStb) begin
      case (regAddr)
        qpc_pkg::OFS_QUAD_CTRL: next_regRdData = qctrl;
        qpc_pkg::OFS_PIN_SWAP: next_regRdData = {31'h0, pinSwapSel};
        qpc_pkg::OFS_FRAME_CMD: next_regRdData = {16'h0, cmdWords, 6'h0, cmdRead, 1'b0};
        qpc_pkg::OFS_FRAME_STAT: next_regRdData = {28'h0, stall, over, under, busy};
        default: next_regRdData = 32'h0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      qctrl      <= qpc_pkg::QCTRL_RESET;
      pinSwapSel <= qpc_pkg::SWAP_RESET;
      cmdRead    <= 1'b0;
      cmdWords   <= 8'h0;
      startReq   <= 1'b0;
      clrUnder   <= 1'b0;
      clrOver    <= 1'b0;
      regRdData  <= 32'h0;
    end else begin
      qctrl      <= next_qctrl;
      pinSwapSel <= next_pinSwapSel;
      cmdRead    <= next_cmdRead;
      cmdWords   <= next_cmdWords;
      startReq   <= next_startReq;
      clrUnder   <= next_clrUnder;
      clrOver    <= next_clrOver;
      regRdData  <= next_regRdData;
    end
  end

  // configuration decode; software keeps it steady during a frame
  always_comb begin
    instr_addr_format     = qctrl[qpc_pkg::IAT_LSB +: 2];
    alen    = qctrl[qpc_pkg::ALEN_LSB +: 4];
    ilen    = qctrl[qpc_pkg::ILEN_LSB +: 2];
    waitCnt = qctrl[qpc_pkg::WAIT_LSB +: 5];
    stretch = qctrl[qpc_pkg::STRETCH_BIT];
    quad    = (spiFrf == qpc_pkg::FRF_QUAD);
    case (spiFrf)
      qpc_pkg::FRF_DUAL: frfLane = 3'h2;
      qpc_pkg::FRF_QUAD: frfLane = 3'h4;
      default: frfLane = 3'h1;
    endcase
    instrBits = qpc_pkg::STD_INSTR_BITS;
    if (quad) begin
      case (ilen)
        2'h0: instrBits = 7'h00;
        2'h1: instrBits = 7'h04;
        2'h2: instrBits = 7'h08;
        default: instrBits = 7'h10;
      endcase
    end
    // codes above 32 bits clamp: one queued word carries the address
    addrBits  = (alen > qpc_pkg::ALEN_MAX) ? qpc_pkg::WORD_BITS : {1'b0, alen, 2'b00};
    dummyBits = quad ? {2'b00, waitCnt} : 7'h00;
    // reserved format code falls back to single line
    instrLane = (instr_addr_format == qpc_pkg::IAT_BOTH_FRF) ? frfLane : 3'h1;
    addrLane  = (instr_addr_format == qpc_pkg::IAT_ADDR_FRF || instr_addr_format == qpc_pkg::IAT_BOTH_FRF) ?
                frfLane : 3'h1;
  end

  // phase sequencer
  always_comb begin
    next_st = st;
    next_bitsLeft = bitsLeft;
    next_shOut = shOut;
    next_shIn = shIn;
    next_laneW = laneW;
    next_wordsLeft = wordsLeft;
    next_startPend = startPend | startReq;
    next_rdDir = rdDir;
    next_rxPend = rxPend;
    next_sclk = sclk;
    next_csN = csN;
    next_rxValid = rxValid && !rxReady;
    next_rxData = rxData;
    next_stall = 1'b0;
    bufPop = 1'b0;
    doEnter = 1'b0;
    endFrame = 1'b0;
    hold = 1'b0;
    tgt = qpc_pkg::ST_DATA;
    next_under = under & ~clrUnder;
    next_over = over & ~clrOver;
    case (st)
      qpc_pkg::ST_IDLE: begin
        if (startPend && (addrBits == 7'h00 || bufValid)) begin
          next_startPend = startReq;
          next_csN = 1'b0;
          next_wordsLeft = cmdWords;
          next_rdDir = cmdRead;
          doEnter = 1'b1;
          tgt = (instrBits != 7'h00) ? qpc_pkg::ST_INSTR :
                (addrBits != 7'h00) ? qpc_pkg::ST_ADDR :
                (dummyBits != 7'h00) ? qpc_pkg::ST_DUMMY : qpc_pkg::ST_DATA;
        end
      end
      qpc_pkg::ST_INSTR, qpc_pkg::ST_ADDR, qpc_pkg::ST_DUMMY: begin
        next_sclk = !sclk;
        if (sclk) begin
          next_shOut = shOut << laneW;
          next_bitsLeft = bitsLeft - {4'h0, laneW};
          if (bitsLeft == {4'h0, laneW}) begin
            doEnter = 1'b1;
            if (st == qpc_pkg::ST_INSTR && addrBits != 7'h00) begin
              tgt = qpc_pkg::ST_ADDR;
            end else if (st != qpc_pkg::ST_DUMMY && dummyBits != 7'h00) begin
              tgt = qpc_pkg::ST_DUMMY;
            end
          end
        end
      end
      qpc_pkg::ST_DATA: begin
        if (!sclk && bitsLeft == 7'h00) begin
          if (rxPend) begin
            if (rxValid && !rxReady) begin
              if (stretch) begin
                hold = 1'b1;
              end else begin
                next_rxPend = 1'b0;
                next_over = 1'b1;
              end
            end else begin
              next_rxValid = 1'b1;
              next_rxData = shIn;
              next_rxPend = 1'b0;
            end
          end
          if (hold) begin
            next_stall = 1'b1;
          end else if (wordsLeft == 8'h00) begin
            endFrame = 1'b1;
          end else if (rdDir) begin
            next_bitsLeft = qpc_pkg::WORD_BITS;
            next_wordsLeft = wordsLeft - 8'h01;
            next_sclk = 1'b1;
          end else if (bufValid) begin
            bufPop = 1'b1;
            next_shOut = bufData;
            next_bitsLeft = qpc_pkg::WORD_BITS;
            next_wordsLeft = wordsLeft - 8'h01;
            next_sclk = 1'b1;
          end else if (stretch) begin
            next_stall = 1'b1;
          end else begin
            next_under = 1'b1;
            endFrame = 1'b1;
          end
        end else if (!sclk) begin
          next_sclk = 1'b1;
        end else begin
          next_sclk = 1'b0;
          next_shOut = shOut << laneW;
          next_shIn = (shIn << laneW) | {28'h0, laneW == 3'h4 ? ioSync :
                      laneW == 3'h2 ? {2'b00, ioSync[1:0]} : {3'b000, ioSync[1]}};
          next_bitsLeft = bitsLeft - {4'h0, laneW};
          if (bitsLeft == {4'h0, laneW} && rdDir) begin
            next_rxPend = 1'b1;
          end
        end
      end
      default: endFrame = 1'b1;
    endcase
    if (endFrame) begin
      next_st = qpc_pkg::ST_IDLE;
      next_csN = 1'b1;
      next_sclk = 1'b0;
    end
    if (doEnter) begin
      next_st = tgt;
      case (tgt)
        qpc_pkg::ST_INSTR: begin
          next_shOut = {instrCode, 16'h0000} << (7'h10 - instrBits);
          next_bitsLeft = instrBits;
          next_laneW = instrLane;
        end
        qpc_pkg::ST_ADDR: begin
          bufPop = 1'b1;
          next_shOut = bufData << (qpc_pkg::WORD_BITS - addrBits);
          next_bitsLeft = addrBits;
          next_laneW = addrLane;
        end
        qpc_pkg::ST_DUMMY: begin
          next_bitsLeft = dummyBits;
          next_laneW = 3'h1;
        end
        default: begin
          next_bitsLeft = 7'h00;
          next_laneW = frfLane;
        end
      endcase
    end
    // lanes float in dummy clocks, idle and read data
    next_ioOeN = 4'hf;
    next_ioOut = 4'h0;
    if (next_st == qpc_pkg::ST_INSTR || next_st == qpc_pkg::ST_ADDR ||
        (next_st == qpc_pkg::ST_DATA && !next_rdDir)) begin
      case (next_laneW)
        3'h4: begin next_ioOeN = 4'h0; next_ioOut = next_shOut[31:28]; end
        3'h2: begin next_ioOeN = 4'hc; next_ioOut = {2'b00, next_shOut[31:30]}; end
        default: begin next_ioOeN = 4'he; next_ioOut = {3'b000, next_shOut[31]}; end
      endcase
    end
    next_busy = (next_st != qpc_pkg::ST_IDLE) || next_startPend;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st <= qpc_pkg::ST_IDLE;
      bitsLeft <= 7'h00;
      shOut <= 32'h0;
      shIn <= 32'h0;
      laneW <= 3'h1;
      wordsLeft <= 8'h00;
      startPend <= 1'b0;
      rdDir <= 1'b0;
      rxPend <= 1'b0;
      under <= 1'b0;
      over <= 1'b0;
      stall <= 1'b0;
      sclk <= 1'b0;
      csN <= 1'b1;
      rxValid <= 1'b0;
      rxData <= 32'h0;
      ioOut <= 4'h0;
      ioOeN <= 4'hf;
      busy <= 1'b0;
    end else begin
      st <= next_st;
      bitsLeft <= next_bitsLeft;
      shOut <= next_shOut;
      shIn <= next_shIn;
      laneW <= next_laneW;
      wordsLeft <= next_wordsLeft;
      startPend <= next_startPend;
      rdDir <= next_rdDir;
      rxPend <= next_rxPend;
      under <= next_under;
      over <= next_over;
      stall <= next_stall;
      sclk <= next_sclk;
      csN <= next_csN;
      rxValid <= next_rxValid;
      rxData <= next_rxData;
      ioOut <= next_ioOut;
      ioOeN <= next_ioOeN;
      busy <= next_busy;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence s_enter_dummy;
    st != qpc_pkg::ST_DUMMY ##1 st == qpc_pkg::ST_DUMMY;
  endsequence
  sequence s_tx_starved;
    st == qpc_pkg::ST_DATA && !rdDir && stretch && !sclk && bitsLeft == 7'h00 &&
    wordsLeft != 8'h00 && !bufValid;
  endsequence
  sequence s_rx_blocked;
    st == qpc_pkg::ST_DATA && rxPend && stretch && !sclk && bitsLeft == 7'h00 &&
    rxValid && !rxReady;
  endsequence

  a_instr_none: assert property (quad && ilen == 2'h0 |-> st != qpc_pkg::ST_INSTR)
    else $error("instruction phase entered with zero length");
  a_dummy_len: assert property (s_enter_dummy |-> bitsLeft == {2'b00, waitCnt} && ioOeN == 4'hf)
    else $error("dummy phase length or lanes wrong");
  a_tx_stretch: assert property (s_tx_starved |=> !sclk && st == qpc_pkg::ST_DATA && stall)
    else $error("serial clock ran with transmit data missing");
  a_rx_stretch: assert property (s_rx_blocked |=> !sclk && rxPend && stall)
    else $error("serial clock ran with receive path full");
  a_swap_write: assert property (regWrStb && regAddr == qpc_pkg::OFS_PIN_SWAP |=>
    pinSwapSel == $past(regWrData[0]))
    else $error("pin swap select did not follow write");
  a_addr_format: assert property (st == qpc_pkg::ST_ADDR && instr_addr_format == qpc_pkg::IAT_BOTH_STD |->
    ioOeN == 4'he)
    else $error("address not sent on a single line");
  a_addr_wait: assert property (st == qpc_pkg::ST_IDLE && startPend && addrBits != 7'h00 &&
    !bufValid |=> st == qpc_pkg::ST_IDLE && csN)
    else $error("frame started before address queued");
  a_reserved_zero: assert property (regRdStb && regAddr == qpc_pkg::OFS_QUAD_CTRL |=>
    (regRdData & ~qpc_pkg::QCTRL_MASK) == 32'h0)
    else $error("reserved control bits read nonzero");

endmodule : qpc_frame_ctrl

// *** testbench/qpc_flash_model.sv ***
// qpc_flash_model: serial flash stand-in on the four lanes of the frame block.
// assumes sclk stays high for one clk_sys cycle per serial clock.
`timescale 1ns/100ps
module qpc_flash_model (
  input  wire logic       clk_sys,
  input  wire logic       sclk,
  input  wire logic       csN,
  input  wire logic [3:0] ioOut,
  input  wire logic [3:0] ioOeN,
  output logic      [3:0] ioIn
);
  logic [3:0] nib [$];
  logic [3:0] firstOeN;
  logic [3:0] pat    = 4'h0;
  logic       lastCs = 1'b1;
  int         clkCnt = 0;

  assign ioIn = pat;
  // sample while sclk is high, before the lanes move on the falling edge
  always @(posedge clk_sys) begin
    if (!csN && lastCs) begin
      nib.delete();
      clkCnt = 0;
    end
    if (!csN && sclk) begin
      if (clkCnt == 0) firstOeN = ioOeN;
      nib.push_back(ioOut);
      clkCnt++;
    end
    // steady nibble while selected, so sync latency cannot blur a word; inverted while deselected
    pat <= csN ? ~pat : 4'hc;
    lastCs = csN;
  end
endmodule : qpc_flash_model

// *** testbench/tb.sv ***
// tb: register, phase length, stretch and buffer tests of the quad frame block.
// assumes the flash model on the lanes; the frame format is quad except in the single and dual lane rows.
`timescale 1ns/100ps
module tb;
  localparam logic [11:0] AQ = qpc_pkg::OFS_QUAD_CTRL;
  localparam logic [11:0] AC = qpc_pkg::OFS_FRAME_CMD;
  localparam logic [11:0] AS = qpc_pkg::OFS_FRAME_STAT;
  localparam logic [11:0] AP = qpc_pkg::OFS_PIN_SWAP;
  logic        clk_sys = 1'b0, rst = 1'b1, regWrStb = 1'b0, regRdStb = 1'b0;
  logic        txValid = 1'b0, rxReady = 1'b1;
  logic        txReady, rxValid, sclk, csN, pinSwapSel, busy;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0, txData = 32'h0, regRdData, rxData;
  logic [1:0]  spiFrf = qpc_pkg::FRF_QUAD;
  logic [15:0] instrCode = 16'ha5c3;
  logic [3:0]  ioIn, ioOut, ioOeN;
  int          errors = 0, samples_checked = 0, cycles = 0, rxCount = 0, base, w;
  // cfg: iat, addr len, instr len, dummy count per row; rows 4 and 5 run single and dual lanes
  logic [31:0] cfgTab [7] = '{32'h0000_0002, 32'h0000_2905, 32'h0000_fa22, 32'h0000_0b08,
                              32'h0000_fa22, 32'h0000_fa22, 32'h0000_0107};
  int          clkTab [7] = '{8, 18, 49, 33, 72, 36, 16};
  logic [31:0] oeTab  [7] = '{32'h0, 32'he, 32'h0, 32'he, 32'he, 32'hc, 32'he};
  logic [1:0]  frfTab [7] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h0, 2'h1, 2'h2};
  int          laneTab [7] = '{4, 4, 4, 4, 1, 2, 4};

  qpc_frame_ctrl i_qpc_frame_ctrl (.clk_sys(clk_sys), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
    .spiFrf(spiFrf), .instrCode(instrCode), .txValid(txValid), .txData(txData),
    .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .rxReady(rxReady), .sclk(sclk),
    .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOeN(ioOeN), .pinSwapSel(pinSwapSel),
    .busy(busy));
  qpc_flash_model u_flash (.clk_sys(clk_sys), .sclk(sclk), .csN(csN), .ioOut(ioOut),
    .ioOeN(ioOeN), .ioIn(ioIn));

  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end

  // hang guard, far above the thousand or so cycles the tests need
  always @(posedge clk_sys) begin
    cycles++;
    if (rxValid && rxReady) rxCount++;
    if (cycles == 20000) begin
      errors++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    regAddr   <= a;
    regWrData <= d;
    regWrStb  <= 1'b1;
    @(posedge clk_sys);
    regWrStb  <= 1'b0;
    // one idle edge, so a following write never reassigns the strobe in the same step
    @(posedge clk_sys);
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    regAddr  <= a;
    regRdStb <= 1'b1;
    @(posedge clk_sys);
    regRdStb <= 1'b0;
    #1 d = regRdData;
    @(posedge clk_sys);
  endtask : rd

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] d;
    rd(a, d);
    chk(what, d, exp);
  endtask : rdChk

  // leaves txValid high; the caller drops it
  task automatic push(input logic [31:0] d);
    logic r;
    txValid <= 1'b1;
    txData  <= d;
    do begin
      #1 r = txReady;
      @(posedge clk_sys);
    end while (r !== 1'b1);
  endtask : push

  task automatic startF(input logic [7:0] n, input logic rdDir);
    wr(AC, {16'h0, n, 6'h0, rdDir, 1'b1});
  endtask : startF

  task automatic waitIdle();
    repeat (3) @(posedge clk_sys);
    while (busy !== 1'b0) @(posedge clk_sys);
  endtask : waitIdle

  task automatic waitStall();
    logic [31:0] s;
    do rd(AS, s); while (s[3] !== 1'b1);
  endtask : waitStall

  function automatic logic [31:0] grab(input int from, input int n, input int lw);
    logic [31:0] r = 32'h0;
    for (int j = 0; j < n; j++) r = (r << lw) | (32'(u_flash.nib[from + j]) & ((32'h1 << lw) - 32'h1));
    return r;
  endfunction : grab

  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    rdChk(AQ, 32'h0, "qctrl reset");
    wr(AQ, 32'hffff_ffff);
    rdChk(AQ, 32'h4000_fb3f, "qctrl reserved");
    wr(AP, 32'hffff_ffff);
    rdChk(AP, 32'h1, "swap reserved");
    chk("pinSwapSel on", {31'h0, pinSwapSel}, 32'h1);
    wr(AP, 32'h0);
    wr(12'h0f0, 32'hffff_ffff);
    rdChk(12'h0f0, 32'h0, "unmapped");
    chk("pinSwapSel off", {31'h0, pinSwapSel}, 32'h0);
    $display("test registers done");
    for (int i = 0; i < 7; i++) begin
      spiFrf <= frfTab[i];
      w = laneTab[i];
      wr(AQ, cfgTab[i]);
      if (i > 0) push(32'h1234_5678);
      push(32'hc0de_0000 + 32'(i));
      txValid <= 1'b0;
      startF(8'h1, 1'b0);
      waitIdle();
      chk("clock count", u_flash.clkCnt, clkTab[i]);
      chk("first lanes", {28'h0, u_flash.firstOeN}, oeTab[i]);
      chk("data word", grab(clkTab[i] - 32 / w, 32 / w, w), 32'hc0de_0000 + 32'(i));
      if (i == 2) chk("instr", grab(0, 2, 4), 32'hc3);
      if (i == 2) chk("addr", grab(2, 8, 4), 32'h1234_5678);
    end
    $display("test phases done");
    wr(AQ, 32'h4000_0002);
    push(32'haaaa_0001);
    push(32'haaaa_0002);
    txValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("txReady full", {31'h0, txReady}, 32'h0);
    startF(8'h3, 1'b0);
    waitStall();
    chk("held clocks", u_flash.clkCnt, 32'd16);
    chk("csN held", {31'h0, csN}, 32'h0);
    push(32'haaaa_0003);
    txValid <= 1'b0;
    waitIdle();
    chk("late word", grab(16, 8, 4), 32'haaaa_0003);
    rdChk(AS, 32'h0, "no underrun");
    wr(AQ, 32'h0000_0002);
    push(32'hbbbb_0001);
    txValid <= 1'b0;
    startF(8'h2, 1'b0);
    waitIdle();
    rdChk(AS, 32'h2, "underrun");
    wr(AS, 32'h6);
    $display("test write stretch done");
    wr(AQ, 32'h4000_0002);
    rxReady <= 1'b0;
    base = rxCount;
    startF(8'h6, 1'b1);
    waitStall();
    chk("csN held rx", {31'h0, csN}, 32'h0);
    rxReady <= 1'b1;
    waitIdle();
    repeat (4) @(posedge clk_sys);
    chk("rx words", rxCount - base, 32'd6);
    chk("rx data", rxData, 32'hcccc_cccc);
    rdChk(AS, 32'h0, "no overflow");
    wr(AQ, 32'h0000_0002);
    rxReady <= 1'b0;
    startF(8'h6, 1'b1);
    waitIdle();
    rdChk(AS, 32'h4, "overflow");
    rxReady <= 1'b1;
    $display("test read stretch done");
    close_out();
  end
endmodule : tb
